// *** src/bbs_defs.svh ***
`ifndef BBS_DEFS_SVH
`define BBS_DEFS_SVH

// Avalon register offsets, in bytes.
`define BBS_REG_CMD 4'h0
`define BBS_REG_ADDR 4'h4
`define BBS_REG_WDATA 4'h8
`define BBS_REG_STATUS 4'hC

// Command register bits.
`define BBS_CMD_START 0
`define BBS_CMD_WRITE 1

// Status register bits.
`define BBS_ST_BUSY 0
`define BBS_ST_PFAIL 1
`define BBS_ST_RDATA_LSB 8

// Clock byte window and control byte.
`define BBS_CLOCK_BASE 13'h1FF8
`define BBS_CTRL_ADDR 13'h1FF8
`define BBS_CTRL_READ_HALT 6
`define BBS_CTRL_WRITE_HALT 7

// Bus timing in ns and derived cycles at 50 ns per clock.
`define BBS_CLK_NS 50
`define BBS_T_ACCESS_NS 150
`define BBS_T_WPULSE_NS 130
`define BBS_T_RECOVER_NS 10
`define BBS_T_DHOLD_NS 5
`define BBS_T_WLQZ_NS 70
`define BBS_N_ACCESS ((`BBS_T_ACCESS_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_N_WPULSE ((`BBS_T_WPULSE_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_N_RECOVER ((`BBS_T_RECOVER_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)
`define BBS_N_WLQZ ((`BBS_T_WLQZ_NS + `BBS_CLK_NS - 1) / `BBS_CLK_NS)

`endif

// *** src/bbs_pkg.sv ***
package bbs_pkg;
	typedef enum logic [2:0] {
		BBS_IDLE,
		BBS_RD_WAIT,
		BBS_WR_SETUP,
		BBS_WR_PULSE,
		BBS_WR_HOLD,
		BBS_RECOVER
	} bbs_state_t;
endpackage : bbs_pkg

// *** src/bbs_host.sv ***
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "bbs_defs.svh"

module bbs_host (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [12:0] address_lines,
	output logic chip_enable_low_n,
	output logic chip_enable_high,
	output logic output_enable_n,
	output logic write_enable_n,
	input wire logic [7:0] data_bus_lines_in,
	output logic [7:0] data_bus_lines_out,
	output logic data_bus_lines_oe_n,
	input wire logic power_fail_alert_n
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [7:0] dq_meta, dq_sync;
	logic pf_meta, pf_sync;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
			pf_meta <= 1'b1;
			pf_sync <= 1'b1;
		end else begin
			dq_meta <= data_bus_lines_in;
			dq_sync <= dq_meta;
			pf_meta <= power_fail_alert_n;
			pf_sync <= pf_meta;
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	bbs_pkg::bbs_state_t state;
	logic [2:0] cnt;
	logic [12:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic is_write;
	logic pfail_seen;
	logic start_req;
	logic busy;
	// An accepted command counts as busy at once, so a poll can never see idle before it runs.
	assign busy = (state != bbs_pkg::BBS_IDLE) || start_req;

	// Commands are refused while busy or during power fail so the pins never glitch.
	logic cmd_hit;
	assign cmd_hit = avs_write && avs_address == `BBS_REG_CMD && avs_byteenable[0]
		&& avs_writedata[`BBS_CMD_START];
	// Read data is registered, so a read is held off for one cycle until it stands.
	logic rd_valid;
	assign avs_waitrequest = avs_read && !rd_valid;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rd_valid <= 1'b0;
		else
			rd_valid <= avs_read && !rd_valid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			addr_reg <= 13'h0000;
			wdata_reg <= 8'h00;
			is_write <= 1'b0;
		end else if (avs_write && !busy) begin
			if (avs_address == `BBS_REG_ADDR && avs_byteenable[0])
				addr_reg[7:0] <= avs_writedata[7:0];
			if (avs_address == `BBS_REG_ADDR && avs_byteenable[1])
				addr_reg[12:8] <= avs_writedata[12:8];
			if (avs_address == `BBS_REG_WDATA && avs_byteenable[0])
				wdata_reg <= avs_writedata[7:0];
			if (cmd_hit)
				is_write <= avs_writedata[`BBS_CMD_WRITE];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			start_req <= 1'b0;
		else
			start_req <= cmd_hit && !busy && pf_sync;
	end

	// Power-fail flag is sticky; the set wins over a clear in the same cycle.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			pfail_seen <= 1'b0;
		else if (!pf_sync)
			pfail_seen <= 1'b1;
		else if (avs_write && avs_address == `BBS_REG_STATUS && avs_byteenable[0]
			&& avs_writedata[`BBS_ST_PFAIL])
			pfail_seen <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !rd_valid) begin
			case (avs_address)
			`BBS_REG_ADDR: avs_readdata <= {19'h00000, addr_reg};
			`BBS_REG_WDATA: avs_readdata <= {24'h000000, wdata_reg};
			`BBS_REG_STATUS: avs_readdata <= {16'h0000, rdata_reg, 6'h00, pfail_seen, busy};
			default: avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Memory cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= bbs_pkg::BBS_IDLE;
			cnt <= 3'h0;
		end else begin
			case (state)
			bbs_pkg::BBS_IDLE: begin
				if (start_req) begin
					state <= is_write ? bbs_pkg::BBS_WR_SETUP : bbs_pkg::BBS_RD_WAIT;
					cnt <= 3'h0;
				end
			end
			bbs_pkg::BBS_RD_WAIT: begin
				// Two extra cycles cover the two-stage input synchroniser delay.
				cnt <= cnt + 3'h1;
				if (cnt == 3'(`BBS_N_ACCESS + 2)) begin
					state <= bbs_pkg::BBS_RECOVER;
					cnt <= 3'h0;
				end
			end
			bbs_pkg::BBS_WR_SETUP: begin
				// Address settles a cycle before the write strobe falls.
				state <= bbs_pkg::BBS_WR_PULSE;
				cnt <= 3'h0;
			end
			bbs_pkg::BBS_WR_PULSE: begin
				cnt <= cnt + 3'h1;
				if (cnt == 3'(`BBS_N_WPULSE - 1)) begin
					state <= bbs_pkg::BBS_WR_HOLD;
					cnt <= 3'h0;
				end
			end
			bbs_pkg::BBS_WR_HOLD: begin
				state <= bbs_pkg::BBS_RECOVER;
			end
			bbs_pkg::BBS_RECOVER: begin
				cnt <= cnt + 3'h1;
				if (cnt == 3'(`BBS_N_RECOVER - 1))
					state <= bbs_pkg::BBS_IDLE;
			end
			default: state <= bbs_pkg::BBS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rdata_reg <= 8'h00;
		else if (state == bbs_pkg::BBS_RD_WAIT && cnt == 3'(`BBS_N_ACCESS + 2))
			rdata_reg <= dq_sync;
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	logic next_active, next_state_rd, next_state_wp, next_state_hold;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			address_lines <= 13'h0000;
			chip_enable_low_n <= 1'b1;
			chip_enable_high <= 1'b0;
			output_enable_n <= 1'b1;
			write_enable_n <= 1'b1;
			data_bus_lines_out <= 8'h00;
			data_bus_lines_oe_n <= 1'b1;
		end else begin
			if (start_req && state == bbs_pkg::BBS_IDLE) begin
				address_lines <= addr_reg;
				data_bus_lines_out <= wdata_reg;
			end
			chip_enable_low_n <= !(next_active);
			chip_enable_high <= next_active;
			output_enable_n <= !(next_state_rd);
			write_enable_n <= !(next_state_wp);
			data_bus_lines_oe_n <= !(next_state_wp || next_state_hold);
		end
	end

	always_comb begin
		next_state_rd = 1'b0;
		next_state_wp = 1'b0;
		next_state_hold = 1'b0;
		case (state)
		bbs_pkg::BBS_IDLE: next_state_rd = start_req && !is_write;
		bbs_pkg::BBS_RD_WAIT: next_state_rd = (cnt != 3'(`BBS_N_ACCESS + 2));
		bbs_pkg::BBS_WR_SETUP: next_state_wp = 1'b1;
		bbs_pkg::BBS_WR_PULSE: begin
			next_state_wp = (cnt != 3'(`BBS_N_WPULSE - 1));
			next_state_hold = !next_state_wp;
		end
		default: ;
		endcase
		next_active = next_state_rd || next_state_wp
			|| (state == bbs_pkg::BBS_IDLE && start_req && is_write)
			|| state == bbs_pkg::BBS_WR_SETUP;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	addr_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
		!write_enable_n |-> $stable(address_lines))
		else $error("address moved during write strobe");
	oe_in_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		!write_enable_n |-> output_enable_n)
		else $error("output enable low during write");
	wr_pulse_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(write_enable_n) |-> !write_enable_n [*3] ##1 write_enable_n)
		else $error("write strobe length wrong");
	data_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(write_enable_n) |-> !data_bus_lines_oe_n)
		else $error("write data released with strobe");
	recover_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(chip_enable_low_n) |=> chip_enable_low_n)
		else $error("no recovery gap");
	enable_pair_a: assert property (@(posedge clk) disable iff (!reset_n)
		chip_enable_low_n == !chip_enable_high)
		else $error("chip enables disagree");
	rd_len_a: assert property (@(posedge clk) disable iff (!reset_n)
		$fell(output_enable_n) |-> !output_enable_n [*6] ##1 output_enable_n)
		else $error("read strobe length wrong");
	no_start_pf_a: assert property (@(posedge clk) disable iff (!reset_n)
		!pf_sync && !busy |=> chip_enable_low_n)
		else $error("cycle started in power fail");
	cov_write_c: cover property (@(posedge clk) $rose(write_enable_n));
	cov_read_c: cover property (@(posedge clk) $rose(output_enable_n));
	cov_pfail_c: cover property (@(posedge clk) $rose(pfail_seen));
endmodule : bbs_host

// *** tb/bbs_mem_model.sv ***
`timescale 1ns/1ns
module bbs_mem_model #(parameter int SEC_NS = 20000) (
	input wire logic [12:0] address_lines,
	input wire logic chip_enable_low_n,
	input wire logic chip_enable_high,
	input wire logic output_enable_n,
	input wire logic write_enable_n,
	input wire logic [7:0] host_data,
	input wire logic supply_low,
	output logic [7:0] dev_data,
	output logic dev_drive
);
	logic [7:0] mem [0:8191];
	logic [7:0] last = 8'h00;
	logic valid = 1'h0;
	wire sel = !chip_enable_low_n && chip_enable_high && !supply_low;
	wire wr_mode = sel && !write_enable_n;
	assign dev_drive = sel && !output_enable_n && write_enable_n;
	// Until the access time runs out the lines show the inverse of the last byte.
	always @(address_lines, sel, output_enable_n) begin
		valid = 1'h0;
		valid <= #150 1'h1;
	end
	always @* if (dev_drive && valid) last = mem[address_lines];
	assign dev_data = (dev_drive && valid) ? mem[address_lines] : ~last;
	always @(negedge wr_mode) if (!supply_low) mem[address_lines] <= host_data;
	initial for (int i = 0; i < 8192; i++) mem[i] = 8'h00;
	// The counters live apart from the shadow bytes; only the seconds are copied out,
	// so that host tests of the other clock bytes still read back what they wrote.
	logic [7:0] secs = 8'h00, mins = 8'h00, hours = 8'h00;
	logic [7:0] date = 8'h28, month = 8'h02, year = 8'h24;
	function automatic logic [7:0] bcd_inc(input logic [7:0] b);
		return (b[3:0] == 4'h9) ? {b[7:4] + 4'h1, 4'h0} : b + 8'h01;
	endfunction : bcd_inc
	function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
		if (m == 8'h02) return ((y[7:4] * 10 + y[3:0]) % 4 == 0) ? 8'h29 : 8'h28;
		if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) return 8'h30;
		return 8'h31;
	endfunction : last_day
	initial forever begin
		#SEC_NS;
		secs = (secs == 8'h59) ? 8'h00 : bcd_inc(secs);
		if (secs == 8'h00) mins = (mins == 8'h59) ? 8'h00 : bcd_inc(mins);
		if (secs == 8'h00 && mins == 8'h00) hours = (hours == 8'h23) ? 8'h00 : bcd_inc(hours);
		if (secs == 8'h00 && mins == 8'h00 && hours == 8'h00) begin
			if (date == last_day(month, year)) begin
				date = 8'h01;
				month = (month == 8'h12) ? 8'h01 : bcd_inc(month);
				if (month == 8'h01) year = (year == 8'h99) ? 8'h00 : bcd_inc(year);
			end else date = bcd_inc(date);
		end
		if (!mem[13'h1FF8][6] && !mem[13'h1FF8][7]) mem[13'h1FF9] = secs;
	end
endmodule : bbs_mem_model

// *** tb/battery_backed_sram_clock_port_tb.sv ***
`timescale 1ns/1ns
`include "bbs_defs.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	$display("FAIL %s exp %h got %h", n, e, g); num_errors++; end end
module battery_backed_sram_clock_port_tb;
	logic clk = 1'h0, reset_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0, supply_low = 1'h0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, ce_l_n, ce_h, oe_n, we_n, bus_oe_n, dev_drive, prev_we_n;
	logic [12:0] addr_l, prev_a;
	logic [7:0] host_q, dev_q, got, v;
	int num_errors = 0, num_checks = 0, cycles = 0;
	wire [7:0] bus = !bus_oe_n ? host_q : dev_q;
	bbs_host bbs_host_inst (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.address_lines(addr_l), .chip_enable_low_n(ce_l_n), .chip_enable_high(ce_h),
		.output_enable_n(oe_n), .write_enable_n(we_n), .data_bus_lines_in(bus),
		.data_bus_lines_out(host_q), .data_bus_lines_oe_n(bus_oe_n),
		.power_fail_alert_n(!supply_low));
	bbs_mem_model #(.SEC_NS(20000)) bbs_mem_model_inst (.address_lines(addr_l),
		.chip_enable_low_n(ce_l_n), .chip_enable_high(ce_h), .output_enable_n(oe_n),
		.write_enable_n(we_n), .host_data(host_q), .supply_low(supply_low),
		.dev_data(dev_q), .dev_drive(dev_drive));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		prev_a <= addr_l;
		prev_we_n <= we_n;
		if (reset_n) `CHK("contention", 1'h0, !bus_oe_n && dev_drive)
		if (reset_n && !we_n && !prev_we_n) `CHK("addr_hold", prev_a, addr_l)
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'h0);
		rd = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
	endtask : av
	task automatic mem_op(input logic wr, input logic [12:0] a, input logic [7:0] d);
		int n;
		n = 0;
		av(1'h1, `BBS_REG_ADDR, {19'h0, a});
		av(1'h1, `BBS_REG_WDATA, {24'h0, d});
		av(1'h1, `BBS_REG_CMD, {30'h0, wr, 1'h1});
		av(1'h0, `BBS_REG_STATUS, 32'h0);
		do begin
			av(1'h0, `BBS_REG_STATUS, 32'h0);
			n++;
		end while (rd[0] !== 1'h0 && n < 100);
		`CHK("idle", 1'h0, rd[0])
		got = rd[15:8];
	endtask : mem_op
	task automatic t_rw;
		mem_op(1'h1, 13'h0123, 8'hA5);
		mem_op(1'h1, 13'h1123, 8'h5A);
		mem_op(1'h0, 13'h0123, 8'h00);
		`CHK("rd_0123", 8'hA5, got)
		mem_op(1'h0, 13'h1123, 8'h00);
		`CHK("rd_1123", 8'h5A, got)
		mem_op(1'h1, 13'h1FFF, 8'h99);
		mem_op(1'h0, 13'h1FFF, 8'h00);
		`CHK("rd_1FFF", 8'h99, got)
		$display("test rw done");
	endtask : t_rw
	task automatic t_halt;
		mem_op(1'h1, 13'h1FF8, 8'h40);
		mem_op(1'h0, 13'h1FF9, 8'h00);
		v = got;
		repeat (600) @(posedge clk);
		mem_op(1'h0, 13'h1FF9, 8'h00);
		`CHK("halted", v, got)
		mem_op(1'h1, 13'h1FF8, 8'h00);
		repeat (600) @(posedge clk);
		mem_op(1'h0, 13'h1FF9, 8'h00);
		`CHK("ticking", 1'h1, got !== v)
		`CHK("bcd_sec", 1'h1, got[3:0] <= 4'h9 && got[7:4] <= 4'h5)
		$display("test halt done");
	endtask : t_halt
	task automatic t_pfail;
		mem_op(1'h1, 13'h0200, 8'h11);
		supply_low <= 1'h1;
		repeat (4) @(posedge clk);
		mem_op(1'h1, 13'h0200, 8'h22);
		av(1'h0, `BBS_REG_STATUS, 32'h0);
		av(1'h0, `BBS_REG_STATUS, 32'h0);
		`CHK("pfail_flag", 1'h1, rd[1])
		supply_low <= 1'h0;
		repeat (4) @(posedge clk);
		av(1'h1, `BBS_REG_STATUS, 32'h2);
		mem_op(1'h0, 13'h0200, 8'h00);
		`CHK("protected", 8'h11, got)
		`CHK("pfail_clr", 1'h0, rd[1])
		$display("test pfail done");
	endtask : t_pfail
	initial begin
		repeat (16) @(posedge clk);
		reset_n <= 1'h1;
		t_rw();
		t_halt();
		t_pfail();
		close_out();
	end
endmodule : battery_backed_sram_clock_port_tb
